// *** rtl/gpe_regs.svh ***
// register offsets, field positions, reset values for the event block
// assumes inclusion by bare name from the package and the top module
`ifndef GPE_REGS_SVH
`define GPE_REGS_SVH
`define GPE_CTL_OFFSET 12'h450
`define GPE_STS_OFFSET 12'h454
`define GPE_MUX_OFFSET 12'h458
`define GPE_BIT_INVERT 0
`define GPE_BIT_PORT2 2
`define GPE_BIT_PORT4 4
`define GPE_BIT_GPIO7_ALT 7
`define GPE_CTL_RESET 32'h0000_0000
`define GPE_STS_RESET 32'h0000_0000
`define GPE_CTL_MASK 32'h0000_0015
`define GPE_ADDR_BITS 12
`endif

// *** rtl/gpe_pkg.sv ***
// types for the event block
// assumes gpe_regs.svh on the include path
`include "gpe_regs.svh"
package gpe_pkg;
    typedef struct packed {
        logic port4_event_redirect_en;
        logic port2_event_redirect_en;
        logic event_polarity_invert;
    } gpe_ctl_type;

    typedef struct packed {
        logic port4_event_active;
        logic port2_event_active;
    } gpe_sts_type;

    typedef enum logic [1:0] {
        GPE_IDLE = 2'b00,
        GPE_DATA = 2'b01
    } gpe_bus_state_type;
endpackage

// *** rtl/gpe_pin_mux.sv ***
// gpio 7 pad driver: alternate function or plain gpio
// assumes synchronous inputs on I_CLOCK-domain clk
`timescale 1ns/10ps
module gpe_pin_mux (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_alt_en,
    input wire logic i_event_level,
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe_n,
    output logic o_pin,
    output logic o_pin_oe_n
);
    // pin follows event only in alternate mode
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pin <= 1'b1;
            o_pin_oe_n <= 1'b1;
        end else if (i_alt_en) begin
            o_pin <= i_event_level;
            o_pin_oe_n <= 1'b0;
        end else begin
            o_pin <= i_gpio_out;
            o_pin_oe_n <= i_gpio_oe_n;
        end
    end
endmodule

// *** rtl/gpe_event_top.sv ***
// general purpose event redirect for downstream ports 2 and 4, ahb-lite slave
// assumes one clock, synchronous active-high reset, a sticky-reset input
`timescale 1ns/10ps
`include "gpe_regs.svh"
module gpe_event_top (
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_STICKY_RST,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_PORT2_EVENT,
    input wire logic I_PORT4_EVENT,
    input wire logic I_GPIO7_OUT,
    input wire logic I_GPIO7_OE_N,
    output logic O_PORT2_NOTIFY_EN,
    output logic O_PORT4_NOTIFY_EN,
    output logic O_SHARED_EVENT_OUT,
    output logic O_GPIO7,
    output logic O_GPIO7_OE_N
);
    gpe_pkg::gpe_ctl_type ctl_q;
    gpe_pkg::gpe_sts_type sts_q;
    gpe_pkg::gpe_bus_state_type bus_q;
    logic alt_en_q;
    logic wr_pend_q;
    logic [`GPE_ADDR_BITS-1:0] addr_q;
    logic [31:0] rdata_d;
    logic any_event;
    logic event_level;

    function automatic logic hit(input logic [`GPE_ADDR_BITS-1:0] a, input logic [`GPE_ADDR_BITS-1:0] off);
        hit = (a == off);
    endfunction

    // address phase capture
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            bus_q <= gpe_pkg::GPE_IDLE;
            wr_pend_q <= 1'b0;
            addr_q <= '0;
        end else if (I_HREADY && I_HSEL && I_HTRANS[1]) begin
            bus_q <= gpe_pkg::GPE_DATA;
            wr_pend_q <= I_HWRITE;
            addr_q <= I_HADDR[`GPE_ADDR_BITS-1:0];
        end else if (I_HREADY) begin
            bus_q <= gpe_pkg::GPE_IDLE;
            wr_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_STICKY_RST) begin
            ctl_q <= '0;
        end else if (bus_q == gpe_pkg::GPE_DATA && wr_pend_q && hit(addr_q, `GPE_CTL_OFFSET)) begin
            ctl_q.event_polarity_invert <= I_HWDATA[`GPE_BIT_INVERT];
            ctl_q.port2_event_redirect_en <= I_HWDATA[`GPE_BIT_PORT2];
            ctl_q.port4_event_redirect_en <= I_HWDATA[`GPE_BIT_PORT4];
        end
    end

    // gpio 7 function select
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            alt_en_q <= 1'b0;
        end else if (bus_q == gpe_pkg::GPE_DATA && wr_pend_q && hit(addr_q, `GPE_MUX_OFFSET)) begin
            alt_en_q <= I_HWDATA[`GPE_BIT_GPIO7_ALT];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            sts_q <= '0;
        end else begin
            sts_q.port2_event_active <= I_PORT2_EVENT & ctl_q.port2_event_redirect_en;
            sts_q.port4_event_active <= I_PORT4_EVENT & ctl_q.port4_event_redirect_en;
        end
    end

    assign any_event = sts_q.port2_event_active | sts_q.port4_event_active;
    assign event_level = ctl_q.event_polarity_invert ? any_event : ~any_event;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_PORT2_NOTIFY_EN <= 1'b1;
            O_PORT4_NOTIFY_EN <= 1'b1;
            O_SHARED_EVENT_OUT <= 1'b1;
        end else begin
            O_PORT2_NOTIFY_EN <= ~ctl_q.port2_event_redirect_en;
            O_PORT4_NOTIFY_EN <= ~ctl_q.port4_event_redirect_en;
            O_SHARED_EVENT_OUT <= event_level;
        end
    end

    gpe_pin_mux u_pin (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_alt_en(alt_en_q),
        .i_event_level(event_level),
        .i_gpio_out(I_GPIO7_OUT),
        .i_gpio_oe_n(I_GPIO7_OE_N),
        .o_pin(O_GPIO7),
        .o_pin_oe_n(O_GPIO7_OE_N)
    );

    // read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(I_HADDR[`GPE_ADDR_BITS-1:0], `GPE_CTL_OFFSET)) begin
            rdata_d[`GPE_BIT_INVERT] = ctl_q.event_polarity_invert;
            rdata_d[`GPE_BIT_PORT2] = ctl_q.port2_event_redirect_en;
            rdata_d[`GPE_BIT_PORT4] = ctl_q.port4_event_redirect_en;
        end else if (hit(I_HADDR[`GPE_ADDR_BITS-1:0], `GPE_STS_OFFSET)) begin
            rdata_d[`GPE_BIT_PORT2] = sts_q.port2_event_active;
            rdata_d[`GPE_BIT_PORT4] = sts_q.port4_event_active;
        end else if (hit(I_HADDR[`GPE_ADDR_BITS-1:0], `GPE_MUX_OFFSET)) begin
            rdata_d[`GPE_BIT_GPIO7_ALT] = alt_en_q;
        end
    end

    // read data registered in the address phase, zero wait states
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_HRDATA <= 32'h0000_0000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end else begin
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
            if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
                O_HRDATA <= rdata_d;
            end
        end
    end

    a_status_gated: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        sts_q.port2_event_active |-> $past(ctl_q.port2_event_redirect_en))
        else $error("port2 status set while disabled");
    a_gated_four: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        sts_q.port4_event_active |-> $past(ctl_q.port4_event_redirect_en))
        else $error("port4 status set while disabled");
    a_status_four: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !$past(I_RST) && $past(I_PORT4_EVENT) && $past(ctl_q.port4_event_redirect_en) |-> sts_q.port4_event_active)
        else $error("port4 status missing");
    a_status_two: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !$past(I_RST) && $past(I_PORT2_EVENT) && $past(ctl_q.port2_event_redirect_en) |-> sts_q.port2_event_active)
        else $error("port2 status missing");
    a_status_clear: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        $past(I_RST) |-> sts_q == '0)
        else $error("status not cleared by reset");
    a_notify_two: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        ctl_q.port2_event_redirect_en |=> !O_PORT2_NOTIFY_EN)
        else $error("port2 notification not suppressed");
    a_notify_on_two: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !ctl_q.port2_event_redirect_en |=> O_PORT2_NOTIFY_EN)
        else $error("port2 notification blocked while not redirected");
    a_notify_four: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        ctl_q.port4_event_redirect_en |=> !O_PORT4_NOTIFY_EN)
        else $error("port4 notification not suppressed");
    a_notify_on_four: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !ctl_q.port4_event_redirect_en |=> O_PORT4_NOTIFY_EN)
        else $error("port4 notification blocked while not redirected");
    a_event_polarity: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        any_event |=> O_SHARED_EVENT_OUT == $past(ctl_q.event_polarity_invert))
        else $error("event level wrong polarity");
    a_event_idle: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !any_event |=> O_SHARED_EVENT_OUT != $past(ctl_q.event_polarity_invert))
        else $error("event asserted with nothing pending");
    a_pin_alt: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        alt_en_q |=> O_GPIO7 == $past(event_level) && !O_GPIO7_OE_N)
        else $error("gpio7 not carrying event");
    a_pin_plain: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !alt_en_q |=> O_GPIO7 == $past(I_GPIO7_OUT))
        else $error("gpio7 shows event outside alternate mode");
    a_pin_plain_oe: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        !alt_en_q |=> O_GPIO7_OE_N == $past(I_GPIO7_OE_N))
        else $error("gpio7 enable not following plain gpio");
    a_status_ro: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        wr_pend_q && hit(addr_q, `GPE_STS_OFFSET) && !I_PORT2_EVENT && !I_PORT4_EVENT |=> sts_q == '0)
        else $error("status written by software");
    a_sticky_hold: assert property (@(posedge I_CLOCK)
        I_RST && !I_STICKY_RST && !wr_pend_q |=> $stable(ctl_q))
        else $error("enable lost on plain reset");
endmodule

// *** bench/gpe_event_sink.sv ***
// far-side event logic sampling gpio 7
// assumes a pull-up on the pin; oe low means the switch drives it
`timescale 1ns/10ps
module gpe_event_sink (
    input wire logic i_clk,
    input wire logic i_pin,
    input wire logic i_pin_oe_n,
    input wire logic i_invert,
    output logic o_seen
);
    logic level;
    // pull-up holds a released wire high
    assign level = i_pin_oe_n ? 1'b1 : i_pin;
    always_ff @(posedge i_clk) begin
        o_seen <= (level == i_invert);
    end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the event redirect block
// assumes ahb-lite single word transfers, zero-wait slave
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic clk, rst, srst, hsel, hwrite, rdy, hresp, p2, p4, g_out, g_oe_n;
    logic n2en, n4en, shared, gpio7, gpio7_oe_n, seen;
    logic [31:0] haddr, hwdata, hrdata, v, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] ctl;
    logic alt;
    int n_errors, n_checks;
    always #10 clk = ~clk;
    gpe_event_top i_dut (.I_CLOCK(clk), .I_RST(rst), .I_STICKY_RST(srst), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
        .I_HREADY(rdy), .O_HRDATA(hrdata), .O_HREADYOUT(rdy), .O_HRESP(hresp), .I_PORT2_EVENT(p2),
        .I_PORT4_EVENT(p4), .I_GPIO7_OUT(g_out), .I_GPIO7_OE_N(g_oe_n), .O_PORT2_NOTIFY_EN(n2en),
        .O_PORT4_NOTIFY_EN(n4en), .O_SHARED_EVENT_OUT(shared), .O_GPIO7(gpio7),
        .O_GPIO7_OE_N(gpio7_oe_n));
    gpe_event_sink i_sink (.i_clk(clk), .i_pin(gpio7), .i_pin_oe_n(gpio7_oe_n), .i_invert(ctl[0]),
        .o_seen(seen));
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin n_errors++; final_report(); end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr; hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic check_all();
        logic [31:0] sts;
        logic any;
        sts = {27'h0, p4 & ctl[4], 1'b0, p2 & ctl[2], 2'h0};
        any = (sts != 32'h0);
        ahb(1'b0, 32'h450, 32'h0, rd);
        `CHK(rd, ctl)
        ahb(1'b0, 32'h454, 32'h0, rd);
        `CHK(rd, sts)
        ahb(1'b0, 32'h460, 32'h0, rd);
        `CHK(rd, 32'h0)
        `CHK(hresp, 1'b0)
        `CHK(shared, ctl[0] ? any : !any)
        `CHK(n2en, !ctl[2])
        `CHK(n4en, !ctl[4])
        if (alt) begin
            `CHK(gpio7_oe_n, 1'b0)
            `CHK(seen, any)
        end else begin
            `CHK(gpio7, g_out)
            `CHK(gpio7_oe_n, g_oe_n)
        end
    endtask
    initial begin
        clk = 0; rst = 1; srst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0;
        hwdata = 0; p2 = 0; p4 = 0; g_out = 0; g_oe_n = 1; ctl = 0; alt = 0;
        n_errors = 0; n_checks = 0;
        v = $urandom(19880);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        srst <= 1'b0;
        check_all();
        for (int i = 0; i < 40; i++) begin
            v = $urandom;
            ahb(1'b1, 32'h450, v, rd);
            ctl = v & 32'h15;
            v = $urandom;
            ahb(1'b1, 32'h458, v, rd);
            alt = v[7];
            ahb(1'b1, 32'h454, $urandom, rd);
            ahb(1'b1, 32'h460, $urandom, rd);
            v = $urandom;
            @(posedge clk);
            {p2, p4, g_out, g_oe_n} <= v[3:0];
            repeat (4) @(posedge clk);
            check_all();
            if (i % 10 == 9) begin
                // plain reset keeps the sticky enables, drops alt select
                @(posedge clk);
                rst <= 1'b1;
                @(posedge clk);
                rst <= 1'b0;
                alt = 0;
                repeat (4) @(posedge clk);
                check_all();
                ahb(1'b0, 32'h458, 32'h0, rd);
                `CHK(rd, 32'h0)
            end
        end
        final_report();
    end
endmodule
